// *** dcg_consts.vh ***
// constants of the configuration and gain register block
// included by the register module and the bench; definitions only
`ifndef DCG_CONSTS_VH
`define DCG_CONSTS_VH

// ==========================================================
// serial frame
`define DCG_FRAME_BITS     5'd24
`define DCG_FRAME_RW_BIT   23
`define DCG_FRAME_ADDR_HI  19
`define DCG_FRAME_ADDR_LO  16
`define DCG_CNT_MAX        5'd31

// ==========================================================
// register addresses
`define DCG_ADDR_CONFIG    4'h3
`define DCG_ADDR_GAIN      4'h4

// ==========================================================
// reset values and writable masks
`define DCG_CONFIG_RESET   16'h0000
`define DCG_CONFIG_MASK    16'h3f0f
`define DCG_GAIN_MASK      16'h010f

// ==========================================================
// configuration field positions
`define DCG_ALARM_SOURCE_SELECT_BIT    13
`define DCG_ALARM_PIN_ENABLE_BIT     12
`define DCG_CRC_EN_BIT     11
`define DCG_EARLY_OUTPUT_SHIFT_BIT       10
`define DCG_SERIAL_OUTPUT_DISABLE_BIT       9
`define DCG_REF_PD_BIT     8
`define DCG_CH_HI          3
`define DCG_CH_LO          0

// ==========================================================
// gain field positions
`define DCG_REFERENCE_HALVING_STRAP_BIT     8
`define DCG_BUF_HI         3
`define DCG_BUF_LO         0

`endif

// *** dcg_sync.v ***
// two flip-flop synchroniser for levels entering from outside
// assumes inputs are asynchronous to clk; output is second stage
`timescale 1ns/1ns
`default_nettype none

module dcg_sync #(
    parameter WIDTH = 1
) (
    // clock
    input  wire             clk,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    // no reset: strap levels must reach the logic while it is held
    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end

endmodule

`default_nettype wire

// *** dcg_edge.v ***
// edge detector for a level already synchronised to clk
// assumes level is a synchroniser output; pulses last one cycle
`timescale 1ns/1ns
`default_nettype none

module dcg_edge #(
    parameter IDLE = 1'b0
) (
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // level and edges
    input  wire level,
    output wire rise,
    output wire fall
);

    reg last_reg;

    always @(posedge clk) begin
        if (!nrst) begin
            last_reg <= IDLE;
        end else begin
            last_reg <= level;
        end
    end

    assign rise = level & ~last_reg;
    assign fall = ~level & last_reg;

endmodule

`default_nettype wire

// *** dcg_regs.v ***
// configuration and gain registers behind a four-wire serial link
// assumes a serial clock far slower than clk (at least 8 clk/period)
// and crc_error_flag produced on clk by the frame checker
`timescale 1ns/1ns
`default_nettype none
`include "dcg_consts.vh"

module dcg_regs (
    // clock and reset
    input  wire       clk,
    input  wire       nrst,
    input  wire       soft_reset,
    // serial link pins
    input  wire       sclk,
    input  wire       cs_n,
    input  wire       sdi,
    output reg        shared_output_pin_out,
    output reg        shared_output_pin_oe,
    // straps and alarm sources
    input  wire       reference_halving_strap,
    input  wire       gain_strap,
    input  wire       ref_headroom_low,
    input  wire       crc_error_flag,
    // analogue controls
    output reg        crc_check_enable,
    output reg        reference_powerdown,
    output reg  [3:0] channel_powerdown,
    output reg        reference_halving_enable,
    output reg  [3:0] buffer_double_gain
);

    // ======================================================
    // input synchronisation
    wire [5:0] pins_s;
    wire       sclk_s;
    wire       cs_n_s;
    wire       sdi_s;
    wire       ref_low_s;
    wire       reference_halving_strap_strap_s;
    wire       gain_strap_s;
    wire       sclk_rise;
    wire       sclk_fall;
    wire       cs_rise;
    wire       cs_fall;

    // link pins; chip select shows its true idle level in reset
    dcg_sync #(
        .WIDTH    (3)
    ) u_link_sync (
        .clk      (clk),
        .async_in ({sclk, cs_n, sdi}),
        .sync_out (pins_s[5:3])
    );

    // straps must pass during reset, they load the gain defaults
    dcg_sync #(
        .WIDTH    (3)
    ) u_strap_sync (
        .clk      (clk),
        .async_in ({ref_headroom_low, reference_halving_strap,
                    gain_strap}),
        .sync_out (pins_s[2:0])
    );

    assign sclk_s         = pins_s[5];
    assign cs_n_s         = pins_s[4];
    assign sdi_s          = pins_s[3];
    assign ref_low_s      = pins_s[2];
    assign reference_halving_strap_strap_s = pins_s[1];
    assign gain_strap_s   = pins_s[0];

    dcg_edge #(
        .IDLE (1'b0)
    ) u_sclk_edge (
        .clk   (clk),
        .nrst  (nrst),
        .level (sclk_s),
        .rise  (sclk_rise),
        .fall  (sclk_fall)
    );

    dcg_edge #(
        .IDLE (1'b1)
    ) u_cs_edge (
        .clk   (clk),
        .nrst  (nrst),
        .level (cs_n_s),
        .rise  (cs_rise),
        .fall  (cs_fall)
    );

    // ======================================================
    // register storage
    reg  [15:0] config_reg;
    reg  [15:0] gain_reg;
    reg  [15:0] config_next;
    reg  [15:0] gain_next;
    reg  [15:0] gain_reset_val;
    wire        dev_reset;

    assign dev_reset = !nrst || soft_reset;

    // strap levels set the gain defaults; reserved bits stay zero
    always @* begin
        gain_reset_val = 16'h0000;
        gain_reset_val[`DCG_REFERENCE_HALVING_STRAP_BIT] = reference_halving_strap_strap_s;
        gain_reset_val[`DCG_BUF_HI:`DCG_BUF_LO] = {4{gain_strap_s}};
    end

    // ======================================================
    // serial frame engine
    reg  [23:0] rx_reg;
    reg  [23:0] tx_reg;
    reg  [4:0]  cnt_reg;
    reg  [23:0] rx_next;
    reg  [23:0] tx_next;
    reg  [4:0]  cnt_next;
    reg  [15:0] rd_data;
    wire [3:0]  frame_addr;
    wire        frame_read;
    wire        frame_ok;
    wire        frame_end;
    wire        frame_write;
    wire        frame_active;
    wire        early_output_shift;
    wire        alarm_pin_enable;

    assign early_output_shift       = config_reg[`DCG_EARLY_OUTPUT_SHIFT_BIT];
    assign alarm_pin_enable     = config_reg[`DCG_ALARM_PIN_ENABLE_BIT];
    assign frame_addr = rx_reg[`DCG_FRAME_ADDR_HI:`DCG_FRAME_ADDR_LO];
    assign frame_read = rx_reg[`DCG_FRAME_RW_BIT];
    assign frame_ok   = (cnt_reg == `DCG_FRAME_BITS);

    // a frame counts only when exactly 24 falls were seen
    assign frame_end    = cs_rise && frame_ok;
    assign frame_write  = frame_end && !frame_read;
    assign frame_active = !cs_n_s;

    // read multiplexer; unmapped addresses read as zero
    always @* begin
        case (frame_addr)
            `DCG_ADDR_CONFIG: rd_data = config_reg;
            `DCG_ADDR_GAIN:   rd_data = gain_reg;
            default:          rd_data = 16'h0000;
        endcase
    end

    always @* begin
        rx_next  = rx_reg;
        tx_next  = tx_reg;
        cnt_next = cnt_reg;
        if (cs_fall) begin
            cnt_next = 5'd0;
        end else if (!cs_n_s && sclk_fall) begin
            // sample on falling edge, msb first
            rx_next = {rx_reg[22:0], sdi_s};
            // saturate so an overlong frame never wraps back to 24
            if (cnt_reg != `DCG_CNT_MAX) begin
                cnt_next = cnt_reg + 5'd1;
            end
            if (early_output_shift && !alarm_pin_enable) begin
                tx_next = {tx_reg[22:0], 1'b0};
            end
        end else if (!cs_n_s && sclk_rise) begin
            if ((!early_output_shift || alarm_pin_enable) && cnt_reg != 5'd0) begin
                tx_next = {tx_reg[22:0], 1'b0};
            end
        end else if (cs_rise) begin
            // readback of a read frame shifts out in the next frame
            if (frame_end && frame_read) begin
                tx_next = {rx_reg[23:16], rd_data};
            end else begin
                // wrong-length or write frames queue nothing
                tx_next = 24'h000000;
            end
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            rx_reg  <= 24'h000000;
            tx_reg  <= 24'h000000;
            cnt_reg <= 5'd0;
        end else begin
            rx_reg  <= rx_next;
            tx_reg  <= tx_next;
            cnt_reg <= cnt_next;
        end
    end

    // ======================================================
    // register write path
    always @* begin
        config_next = config_reg;
        gain_next   = gain_reg;
        if (frame_write) begin
            case (frame_addr)
                `DCG_ADDR_CONFIG: begin
                    config_next = rx_reg[15:0] & `DCG_CONFIG_MASK;
                end
                `DCG_ADDR_GAIN: begin
                    gain_next = rx_reg[15:0] & `DCG_GAIN_MASK;
                end
                default: begin
                    config_next = config_reg;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (dev_reset) begin
            config_reg <= `DCG_CONFIG_RESET;
            gain_reg   <= gain_reset_val;
        end else begin
            config_reg <= config_next;
            gain_reg   <= gain_next;
        end
    end

    // ======================================================
    // analogue control outputs
    always @(posedge clk) begin
        if (!nrst) begin
            crc_check_enable         <= 1'b0;
            reference_powerdown      <= 1'b0;
            channel_powerdown        <= 4'h0;
            reference_halving_enable <= 1'b0;
            buffer_double_gain       <= 4'h0;
        end else begin
            crc_check_enable    <= config_reg[`DCG_CRC_EN_BIT];
            reference_powerdown <= config_reg[`DCG_REF_PD_BIT];
            channel_powerdown   <=
                config_reg[`DCG_CH_HI:`DCG_CH_LO];
            reference_halving_enable <=
                gain_reg[`DCG_REFERENCE_HALVING_STRAP_BIT];
            buffer_double_gain <=
                gain_reg[`DCG_BUF_HI:`DCG_BUF_LO];
        end
    end

    // ======================================================
    // shared output pin
    reg alarm_active;
    reg pin_out_next;
    reg pin_oe_next;

    // reference alarm is the synchronised headroom comparator
    always @* begin
        if (config_reg[`DCG_ALARM_SOURCE_SELECT_BIT]) begin
            alarm_active = ref_low_s;
        end else begin
            alarm_active = crc_error_flag;
        end
    end

    // pin mode follows the alarm enable bit
    always @* begin
        if (alarm_pin_enable) begin
            // open drain: pull low only while alarm present
            pin_out_next = 1'b0;
            pin_oe_next  = alarm_active;
        end else begin
            pin_out_next = tx_next[23];
            if (config_reg[`DCG_SERIAL_OUTPUT_DISABLE_BIT]) begin
                pin_oe_next = 1'b0;
            end else begin
                pin_oe_next = frame_active;
            end
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            shared_output_pin_out <= 1'b0;
            shared_output_pin_oe  <= 1'b0;
        end else begin
            shared_output_pin_out <= pin_out_next;
            shared_output_pin_oe  <= pin_oe_next;
        end
    end

endmodule

`default_nettype wire

// *** dcg_regs_asserts.sv ***
// port-level checker of the configuration and gain register block
// assumes it is bound to dcg_regs and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module dcg_regs_asserts (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       soft_reset,
    // link pins
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       sdi,
    input wire logic       shared_output_pin_out,
    input wire logic       shared_output_pin_oe,
    // straps and alarms
    input wire logic       reference_halving_strap,
    input wire logic       gain_strap,
    input wire logic       ref_headroom_low,
    input wire logic       crc_error_flag,
    // controls
    input wire logic       crc_check_enable,
    input wire logic       reference_powerdown,
    input wire logic [3:0] channel_powerdown,
    input wire logic       reference_halving_enable,
    input wire logic [3:0] buffer_double_gain
);
    logic        cs_q;
    logic        sk_q;
    logic [3:0]  t_cs;
    logic [3:0]  t_sk;
    logic [3:0]  t_rs;
    logic [10:0] ctl;
    assign ctl = {reference_halving_enable, buffer_double_gain,
                  crc_check_enable, reference_powerdown, channel_powerdown};
    // =====
    // cycles since frame end, link clock edge, reset
    function automatic logic [3:0] sat(input logic [3:0] v);
        return (v == 4'hf) ? v : v + 4'h1;
    endfunction
    always @(posedge clk) begin
        cs_q <= cs_n;
        sk_q <= sclk;
        t_cs <= (!nrst || (cs_n && !cs_q)) ? 4'h0 : sat(t_cs);
        t_sk <= (!nrst || (sclk != sk_q)) ? 4'h0 : sat(t_sk);
        t_rs <= (!nrst || soft_reset) ? 4'h0 : sat(t_rs);
    end
    // =====
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence held_s;
        !nrst [*4] ##1 nrst [*3];
    endsequence
    property strap_p;
        disable iff (1'b0) held_s |-> buffer_double_gain == {4{gain_strap}}
            && reference_halving_enable == reference_halving_strap;
    endproperty
    rst_zero_a: assert property (disable iff (1'b0)
        !nrst [*2] |-> ctl == 11'h0 && !shared_output_pin_oe)
        else $error("outputs not quiet in reset");
    strap_load_a: assert property (strap_p)
        else $error("strap values not loaded");
    idle_float_a: assert property (
        (cs_n && !crc_error_flag && !ref_headroom_low) [*7]
        |-> !shared_output_pin_oe) else $error("pin driven while idle");
    alarm_low_a: assert property (cs_n [*6] ##0 shared_output_pin_oe
        |-> !shared_output_pin_out) else $error("alarm pin not low");
    soft_reset_a: assert property (soft_reset |-> ##3
        ctl == {reference_halving_strap, {4{gain_strap}}, 6'h0})
        else $error("soft reset values wrong");
    frame_end_a: assert property (!$stable(ctl)
        |-> t_cs <= 4'd8 || t_rs <= 4'd4)
        else $error("control changed mid frame");
    shift_edge_a: assert property (!cs_n [*8] ##0
        !$stable(shared_output_pin_out) |-> t_sk <= 4'd6)
        else $error("output moved without clock edge");
    release_a: assert property ($rose(nrst) |->
        !shared_output_pin_oe) else $error("pin driven at release");
endmodule
bind dcg_regs dcg_regs_asserts u_chk (.clk, .nrst, .soft_reset, .sclk,
    .cs_n, .sdi, .shared_output_pin_out, .shared_output_pin_oe,
    .reference_halving_strap, .gain_strap, .ref_headroom_low,
    .crc_error_flag, .crc_check_enable, .reference_powerdown,
    .channel_powerdown, .reference_halving_enable, .buffer_double_gain);
`default_nettype wire

// *** dcg_host_model.sv ***
// serial host that sends frames on the register link
// assumes the bench clock; pin is the resolved shared pin level
`timescale 1ns/1ns
`default_nettype none
module dcg_host_model (
    // clock
    input  wire logic clk,
    // link
    input  wire logic pin,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    // =====
    // one frame of n bits, msb first; s holds the pin seen per bit
    task automatic frame(input logic [23:0] w, input int n,
                         output logic [23:0] s);
        s = 24'h0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            sdi  = w[23-i];
            repeat (2) @(negedge clk);
            s[23-i] = pin;
            repeat (2) @(negedge clk);
            sclk = 1'b0;
            repeat (4) @(negedge clk);
        end
        cs_n = 1'b1;
        sdi  = ~sdi;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb_dac_config_gain_registers.sv ***
// self-checking bench of dcg_regs driven over its serial link
// assumes dcg_host_model as link master; the pin has a pull-up
`timescale 1ns/1ns
`default_nettype none
`include "dcg_consts.vh"
module tb_dac_config_gain_registers;
    logic clk = 1'b0, nrst = 1'b0, soft_reset = 1'b0;
    logic reference_halving_strap = 1'b1, gain_strap = 1'b0;
    logic ref_headroom_low = 1'b0, crc_error_flag = 1'b0;
    wire  sclk, cs_n, sdi, shared_output_pin_out, shared_output_pin_oe;
    wire  crc_check_enable, reference_powerdown, reference_halving_enable;
    wire  [3:0] channel_powerdown, buffer_double_gain;
    wire  pin = shared_output_pin_oe ? shared_output_pin_out : 1'b1;
    wire  [23:0] ctl = {13'h0, reference_halving_enable, buffer_double_gain,
                        crc_check_enable, reference_powerdown, channel_powerdown};
    int   n_errors = 0, check_count = 0;
    logic [23:0] s;
    always #10 clk = ~clk;
    dcg_regs dut_u (.clk, .nrst, .soft_reset, .sclk, .cs_n, .sdi,
        .shared_output_pin_out, .shared_output_pin_oe,
        .reference_halving_strap, .gain_strap, .ref_headroom_low,
        .crc_error_flag, .crc_check_enable, .reference_powerdown,
        .channel_powerdown, .reference_halving_enable, .buffer_double_gain);
    dcg_host_model host (.clk, .pin, .sclk, .cs_n, .sdi);
    // =====
    // tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        host.frame({4'h0, a, d}, 24, s);
    endtask
    // readback shows in the next frame; slow mode lags one bit
    task automatic rd(input logic [3:0] a, input logic f, input logic [15:0] d);
        logic [23:0] e;
        e = {4'h8, a, d};
        host.frame({4'h8, a, 16'h0}, 24, s);
        host.frame(24'h0, 24, s);
        chk(s, f ? e : {e[23], e[23:1]});
    endtask
    task automatic rst;
        nrst = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        results;
    end
    // =====
    // sequence
    initial begin
        rst;
        chk(ctl, 24'h000400);
        rd(`DCG_ADDR_CONFIG, 1'b0, 16'h0000);
        rd(`DCG_ADDR_GAIN, 1'b0, 16'h0100);
        reference_halving_strap = 1'b0;
        gain_strap = 1'b1;
        rst;
        chk(ctl, 24'h0003c0);
        wr(`DCG_ADDR_CONFIG, 16'hc9ff);
        chk(ctl, 24'h0003ff);
        rd(`DCG_ADDR_CONFIG, 1'b0, 16'h090f);
        wr(`DCG_ADDR_GAIN, 16'hfff5);
        chk(ctl, 24'h00057f);
        rd(`DCG_ADDR_GAIN, 1'b0, 16'h0105);
        host.frame(24'h030000, 23, s);
        chk(ctl, 24'h00057f);
        wr(4'h5, 16'hffff);
        rd(4'h5, 1'b0, 16'h0000);
        wr(`DCG_ADDR_CONFIG, 16'h0400);
        rd(`DCG_ADDR_CONFIG, 1'b1, 16'h0400);
        wr(`DCG_ADDR_CONFIG, 16'h0200);
        host.frame(24'h830000, 24, s);
        chk(s, 24'hffffff);
        crc_error_flag = 1'b1;
        wr(`DCG_ADDR_CONFIG, 16'h1000);
        chk({23'h0, pin}, 24'h0);
        crc_error_flag = 1'b0;
        ref_headroom_low = 1'b1;
        repeat (6) @(negedge clk);
        chk({23'h0, pin}, 24'h1);
        wr(`DCG_ADDR_CONFIG, 16'h3600);
        chk({23'h0, pin}, 24'h0);
        ref_headroom_low = 1'b0;
        crc_error_flag = 1'b1;
        repeat (6) @(negedge clk);
        chk({23'h0, pin}, 24'h1);
        crc_error_flag = 1'b0;
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        repeat (4) @(negedge clk);
        chk(ctl, 24'h0003c0);
        results;
    end
endmodule
`default_nettype wire
